// ==== adc_ctrl_regs.sv ====
// control and status register bank of the compressed-audio decoder
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_ctrl_regs
   import adc_pkg::*;
#(
   parameter logic [`ADC_DATA_W-1:0] REVISION   = 8'h01, // arbitrary value
   parameter logic [`ADC_DATA_W-1:0] IDENT_CODE = 8'h5A  // arbitrary value
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // byte port from the control bus engine
   input  wire logic                   bus_sub_load,
   input  wire logic                   bus_wr,
   input  wire logic                   bus_rd,
   input  wire logic [`ADC_DATA_W-1:0] bus_wdata,
   output logic      [`ADC_DATA_W-1:0] bus_rdata,
   output logic                        bus_rvalid,
   // clock and pad control
   output logic                        load_fraction,
   output logic                        crystal_to_out_divider,
   output logic                        crystal_to_sys_divider,
   output logic                        vco_off,
   output logic                        sysclk_on_outclk,
   output logic                        outclk_pad_on,
   output logic                        osc_out_pad_off,
   output logic                        shared_pin_on,
   output logic      [`ADC_DATA_W-1:0] pll_multiplier,
   output logic      [`ADC_DATA_W-1:0] pll_input_divider,
   // serial bitstream input pins
   input  wire logic                   serial_input_clock,
   input  wire logic                   serial_input_data,
   output logic                        sdi_bit,
   output logic                        sdi_valid,
   // data request and shared pin
   output logic                        data_req_line,
   output logic                        shared_pin_req_mode,
   // decoder core
   input  wire logic                   dec_in_decode,
   input  wire logic                   dec_wants_data,
   input  wire logic                   dec_crc_fail,
   input  wire logic                   dec_data_missing,
   input  wire logic [1:0]             dec_sync_state,
   input  wire logic                   dec_anc_valid,
   input  wire logic [`ADC_DATA_W-1:0] dec_anc_byte,
   output logic                        anc_load_req,
   output logic                        soft_reset_pulse,
   output logic                        play_active,
   output logic                        mute_active
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   adc_state_t st_ff;
   adc_state_t nxt_st;

   logic [`ADC_DATA_W-1:0] anc_q;
   logic                   anc_wr;
   logic                   anc_rd;
   logic [2:0]             anc_rd_idx;
   logic                   sck_edge;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic is_anc(input logic [`ADC_ADDR_W-1:0] a);
      is_anc = (a >= `ADC_A_ANC_FIRST) && (a <= `ADC_A_ANC_LAST);
   endfunction

   function automatic logic [`ADC_DATA_W-1:0] reg_read(
      input logic [`ADC_ADDR_W-1:0] a,
      input adc_state_t             s,
      input logic [1:0]             sync
   );
      logic [`ADC_DATA_W-1:0] v;
      v = '0;
      case (a)
         `ADC_A_REVISION: v = REVISION;
         `ADC_A_IDENT:    v = IDENT_CODE;
         `ADC_A_CLKPAD:   v = s.clkpad;
         `ADC_A_PLL_MUL:  v = s.pll_mul;
         `ADC_A_PLL_DIV:  v = s.pll_div;
         `ADC_A_REQUEST_LINE_POLARITY: begin
            v[`ADC_REQ_ON_BIT]  = s.req_on;
            v[`ADC_POL_INV_BIT] = s.req_inv;
         end
         `ADC_A_SCK_POL:  v[`ADC_POL_INV_BIT] = s.sck_fall;
         `ADC_A_ERROR:    v = `ADC_DATA_W'(s.err);
         `ADC_A_PLAY:     v[`ADC_CMD_BIT] = s.play;
         `ADC_A_MUTE:     v[`ADC_CMD_BIT] = s.mute;
         `ADC_A_ANC_CMD:  v = s.anc_cmd;
         `ADC_A_PIN_FUNC: v[`ADC_PIN_REQ_BIT] = s.pin_req;
         `ADC_A_SYNC:     v = `ADC_DATA_W'(sync);
         // write-only and unmapped addresses read as zero
         default:         v = '0;
      endcase
      return v;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   // pin inputs: [0] first, [1] second, [2] third flop
   assign sck_edge = (st_ff.sck_sync[1] == st_ff.sck_sync[2])
                   && (st_ff.sck_sync[2] != st_ff.sck_stable)
                   && (st_ff.sck_sync[2] == ~st_ff.sck_fall);

   always_comb begin
      nxt_st            = st_ff;
      nxt_st.rvalid     = 1'b0;
      nxt_st.soft_pulse = 1'b0;
      nxt_st.sdi_valid  = 1'b0;

      // synchronisers; a change counts once second and third agree
      nxt_st.sck_sync = {st_ff.sck_sync[1:0], serial_input_clock};
      nxt_st.sdi_sync = {st_ff.sdi_sync[1:0], serial_input_data};
      if (st_ff.sck_sync[1] == st_ff.sck_sync[2]) begin
         nxt_st.sck_stable = st_ff.sck_sync[2];
      end
      if (st_ff.sdi_sync[1] == st_ff.sdi_sync[2]) begin
         nxt_st.sdi_stable = st_ff.sdi_sync[2];
      end
      // data passes the same three stages, so it lines up with the clock
      if (sck_edge) begin
         nxt_st.sdi_bit   = nxt_st.sdi_stable;
         nxt_st.sdi_valid = 1'b1;
      end

      // registered request line, low-active when the invert bit is set
      nxt_st.req_line = dec_wants_data ^ st_ff.req_inv;

      // ancillary refill; completion clears the command first so that
      // a host write in the same cycle wins
      unique case (st_ff.anc_st)
         ADC_ANC_IDLE: begin
            if (st_ff.anc_cmd != '0) begin
               nxt_st.anc_st  = ADC_ANC_FILL;
               nxt_st.anc_idx = '0;
            end
         end
         ADC_ANC_FILL: begin
            if (dec_anc_valid) begin
               nxt_st.anc_idx = st_ff.anc_idx + 3'h1;
               if (32'(st_ff.anc_idx) == `ADC_ANC_BYTES - 1) begin
                  nxt_st.anc_st  = ADC_ANC_IDLE;
                  nxt_st.anc_cmd = '0;
               end
            end
         end
      endcase

      // control bus bytes
      if (bus_sub_load) begin
         nxt_st.ptr = bus_wdata[`ADC_ADDR_W-1:0];
      end else if (bus_wr) begin
         nxt_st.ptr = st_ff.ptr + `ADC_ADDR_W'(1);
         // read-only and unmapped targets ignore the byte
         case (st_ff.ptr)
            `ADC_A_CLKPAD:  nxt_st.clkpad  = bus_wdata;
            `ADC_A_PLL_MUL: nxt_st.pll_mul = bus_wdata;
            `ADC_A_PLL_DIV: nxt_st.pll_div = bus_wdata;
            `ADC_A_REQUEST_LINE_POLARITY: begin
               nxt_st.req_on  = bus_wdata[`ADC_REQ_ON_BIT];
               nxt_st.req_inv = bus_wdata[`ADC_POL_INV_BIT];
            end
            `ADC_A_SCK_POL: nxt_st.sck_fall = bus_wdata[`ADC_POL_INV_BIT];
            `ADC_A_SOFT_RST: begin
               // any value triggers it, bit 0 included or not
               nxt_st.soft_pulse = 1'b1;
               nxt_st.play       = `ADC_RST_PLAY;
               nxt_st.mute       = `ADC_RST_MUTE;
               nxt_st.anc_cmd    = `ADC_RST_ANC_CMD;
               nxt_st.anc_st     = ADC_ANC_IDLE;
               nxt_st.anc_idx    = '0;
               nxt_st.err        = `ADC_ERR_NONE;
            end
            `ADC_A_PLAY:     nxt_st.play    = bus_wdata[`ADC_CMD_BIT];
            `ADC_A_MUTE:     nxt_st.mute    = bus_wdata[`ADC_CMD_BIT];
            `ADC_A_ANC_CMD:  nxt_st.anc_cmd = bus_wdata;
            `ADC_A_PIN_FUNC: nxt_st.pin_req = bus_wdata[`ADC_PIN_REQ_BIT];
            default: begin
            end
         endcase
      end else if (bus_rd) begin
         nxt_st.ptr    = st_ff.ptr + `ADC_ADDR_W'(1);
         nxt_st.rdata  = reg_read(st_ff.ptr, st_ff, dec_sync_state);
         nxt_st.rd_anc = is_anc(st_ff.ptr);
         nxt_st.rvalid = 1'b1;
      end

      // error events after the soft reset clear, so the clear never drops one; a CRC fail wins over missing data in the same cycle
      if (dec_crc_fail) begin
         nxt_st.err = `ADC_ERR_CRC;
      end else if (dec_data_missing) begin
         nxt_st.err = `ADC_ERR_NODATA;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff            <= '0;
         st_ff.clkpad     <= `ADC_RST_CLKPAD;
         st_ff.pll_mul    <= `ADC_RST_PLL_MUL;
         st_ff.pll_div    <= `ADC_RST_PLL_DIV;
         st_ff.req_on     <= `ADC_RST_REQ_ON;
         st_ff.req_inv    <= `ADC_RST_REQ_INV;
         st_ff.sck_fall   <= `ADC_RST_SCK_FALL;
         st_ff.err        <= `ADC_ERR_NONE;
         st_ff.play       <= `ADC_RST_PLAY;
         st_ff.mute       <= `ADC_RST_MUTE;
         st_ff.anc_cmd    <= `ADC_RST_ANC_CMD;
         st_ff.pin_req    <= `ADC_RST_PIN_REQ;
         st_ff.anc_st     <= ADC_ANC_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // ancillary buffer
   // -----------------------------------------------------------------
   assign anc_wr     = (st_ff.anc_st == ADC_ANC_FILL) && dec_anc_valid;
   assign anc_rd     = bus_rd && !bus_sub_load && is_anc(st_ff.ptr);
   assign anc_rd_idx = 3'(st_ff.ptr - `ADC_A_ANC_FIRST);

   adc_anc_buf #(
      .WIDTH (`ADC_DATA_W),
      .DEPTH (`ADC_ANC_BYTES),
      .AW    (3)
   ) u_anc_buf (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clr     (st_ff.soft_pulse),
      .wr_en   (anc_wr),
      .wr_idx  (st_ff.anc_idx),
      .wr_data (dec_anc_byte),
      .rd_en   (anc_rd),
      .rd_idx  (anc_rd_idx),
      .rd_data (anc_q)
   );

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // both sources are flops; only the select is muxed late
   assign bus_rdata  = st_ff.rd_anc ? anc_q : st_ff.rdata;
   assign bus_rvalid = st_ff.rvalid;

   // all clock and PLL controls leave from flops, so the decoder never sees a half-written byte
   assign load_fraction          = st_ff.clkpad[`ADC_CC_LOAD_PLL_FRACTION];
   assign crystal_to_out_divider = st_ff.clkpad[`ADC_CC_XTAL_OUT];
   assign crystal_to_sys_divider = st_ff.clkpad[`ADC_CC_XTAL_SYS];
   assign vco_off                = st_ff.clkpad[`ADC_CC_VCO_OFF];
   assign sysclk_on_outclk       = st_ff.clkpad[`ADC_CC_SYS_OUT];
   assign outclk_pad_on          = st_ff.clkpad[`ADC_CC_OUT_PAD];
   assign osc_out_pad_off        = st_ff.clkpad[`ADC_CC_OSC_OFF];
   assign shared_pin_on          = st_ff.clkpad[`ADC_CC_SHARED_ON];
   assign pll_multiplier         = st_ff.pll_mul;
   assign pll_input_divider      = st_ff.pll_div;

   assign sdi_bit   = st_ff.sdi_bit;
   assign sdi_valid = st_ff.sdi_valid;

   assign data_req_line       = st_ff.req_line;
   assign shared_pin_req_mode = st_ff.pin_req;

   assign anc_load_req     = (st_ff.anc_st == ADC_ANC_FILL);
   assign soft_reset_pulse = st_ff.soft_pulse;
   assign play_active      = st_ff.play && dec_in_decode;
   // mute does not touch outclk_pad_on, so the clock keeps running
   assign mute_active      = st_ff.mute;

endmodule // adc_ctrl_regs

// ==== adc_defines.svh ====
// named offsets, field positions, reset values and codes of the decoder control register bank
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define ADC_ADDR_W        7
`define ADC_DATA_W        8
`define ADC_ANC_BYTES     5

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define ADC_A_REVISION    7'h00
`define ADC_A_IDENT       7'h01
`define ADC_A_CLKPAD      7'h05
`define ADC_A_PLL_MUL     7'h06
`define ADC_A_PLL_DIV     7'h07
`define ADC_A_REQUEST_LINE_POLARITY     7'h0C
`define ADC_A_SCK_POL     7'h0D
`define ADC_A_ERROR       7'h0F
`define ADC_A_SOFT_RST    7'h10
`define ADC_A_PLAY        7'h13
`define ADC_A_MUTE        7'h14
`define ADC_A_ANC_CMD     7'h16
`define ADC_A_PIN_FUNC    7'h18
`define ADC_A_SYNC        7'h40
`define ADC_A_ANC_FIRST   7'h59
`define ADC_A_ANC_LAST    7'h5D

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ADC_RST_CLKPAD    8'h21
`define ADC_RST_PLL_MUL   8'h0C
`define ADC_RST_PLL_DIV   8'h00
`define ADC_RST_REQ_ON    1'b1
`define ADC_RST_REQ_INV   1'b0
`define ADC_RST_SCK_FALL  1'b1
`define ADC_RST_PLAY      1'b1
`define ADC_RST_MUTE      1'b0
`define ADC_RST_ANC_CMD   8'h00
`define ADC_RST_PIN_REQ   1'b0

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define ADC_CC_LOAD_PLL_FRACTION  0
`define ADC_CC_XTAL_OUT   1
`define ADC_CC_XTAL_SYS   2
`define ADC_CC_VCO_OFF    3
`define ADC_CC_SYS_OUT    4
`define ADC_CC_OUT_PAD    5
`define ADC_CC_OSC_OFF    6
`define ADC_CC_SHARED_ON  7
`define ADC_REQ_ON_BIT    0
`define ADC_POL_INV_BIT   2
`define ADC_CMD_BIT       0
`define ADC_PIN_REQ_BIT   2

// -----------------------------------------------------------------
// error codes
// -----------------------------------------------------------------
`define ADC_ERR_NONE      2'h0
`define ADC_ERR_CRC       2'h1
`define ADC_ERR_NODATA    2'h2

`endif

// ==== adc_pkg.sv ====
// types shared by the decoder control register bank
`include "adc_defines.svh"

package adc_pkg;

   typedef enum logic [0:0] {
      ADC_ANC_IDLE = 1'b0,
      ADC_ANC_FILL = 1'b1
   } adc_anc_st_t;

   typedef enum logic [1:0] {
      ADC_SYNC_SEARCH  = 2'b00,
      ADC_SYNC_CONFIRM = 2'b01,
      ADC_SYNC_LOCKED  = 2'b10,
      ADC_SYNC_UNUSED  = 2'b11
   } adc_sync_st_t;

   typedef struct packed {
      logic [`ADC_ADDR_W-1:0] ptr;
      logic [`ADC_DATA_W-1:0] clkpad;
      logic [`ADC_DATA_W-1:0] pll_mul;
      logic [`ADC_DATA_W-1:0] pll_div;
      logic                   req_on;
      logic                   req_inv;
      logic                   sck_fall;
      logic [1:0]             err;
      logic                   play;
      logic                   mute;
      logic [`ADC_DATA_W-1:0] anc_cmd;
      logic                   pin_req;
      adc_anc_st_t            anc_st;
      logic [2:0]             anc_idx;
      logic [`ADC_DATA_W-1:0] rdata;
      logic                   rvalid;
      logic                   rd_anc;
      logic                   soft_pulse;
      logic                   req_line;
      logic [2:0]             sck_sync;
      logic [2:0]             sdi_sync;
      logic                   sck_stable;
      logic                   sdi_stable;
      logic                   sdi_bit;
      logic                   sdi_valid;
   } adc_state_t;

endpackage

// ==== adc_anc_buf.sv ====
// five-byte ancillary data buffer with registered read data
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_anc_buf
   import adc_pkg::*;
#(
   parameter int WIDTH = `ADC_DATA_W,
   parameter int DEPTH = `ADC_ANC_BYTES,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clr,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_idx,
   output logic      [WIDTH-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            q;
   } adc_buf_state_t;

   adc_buf_state_t st_ff;
   adc_buf_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      // soft reset empties the buffer, a same-cycle refill byte still lands
      if (clr) begin
         nxt_st.mem = '0;
      end
      if (wr_en && (32'(wr_idx) < DEPTH)) begin
         nxt_st.mem[wr_idx] = wr_data;
      end
      if (rd_en) begin
         nxt_st.q = (32'(rd_idx) < DEPTH) ? st_ff.mem[rd_idx] : '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data = st_ff.q;

endmodule // adc_anc_buf

// ==== adc_ctrl_regs_chk.sv ====
// assertions on the ports of the decoder control register bank
`timescale 1ns/1ps
module adc_ctrl_regs_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic bus_sub_load,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_rvalid,
   input wire logic load_fraction,
   input wire logic outclk_pad_on,
   input wire logic vco_off,
   input wire logic shared_pin_on,
   input wire logic sdi_valid,
   input wire logic anc_load_req,
   input wire logic soft_reset_pulse,
   input wire logic play_active,
   input wire logic mute_active,
   input wire logic dec_in_decode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ------
   // request steps
   // ------
   sequence s_rd;
      bus_rd && !bus_sub_load && !bus_wr;
   endsequence
   sequence s_srst;
      soft_reset_pulse ##1 !soft_reset_pulse;
   endsequence
   AST_RD_ANSWER: assert property (s_rd |=> bus_rvalid)
      else $error("read not answered next cycle");
   AST_RD_ONLY: assert property (!bus_rd |=> !bus_rvalid)
      else $error("answer without a read");
   AST_PLAY_GATE: assert property (play_active |-> dec_in_decode)
      else $error("play active outside decode");
   AST_SRST_ONE: assert property (soft_reset_pulse |-> s_srst)
      else $error("soft reset pulse too long");
   AST_SRST_CAUSE: assert property ($rose(soft_reset_pulse) |-> $past(bus_wr))
      else $error("soft reset without a write");
   AST_SRST_MUTE: assert property (soft_reset_pulse |-> !mute_active)
      else $error("mute kept over soft reset");
   AST_ANC_CAUSE: assert property ($rose(anc_load_req) |-> $past(bus_wr, 2))
      else $error("refill without a command write");
   AST_SDI_GAP: assert property (sdi_valid |=> !sdi_valid [*3])
      else $error("sample pulses too close");
   AST_RST_VAL: assert property ($fell(rst) |-> load_fraction && outclk_pad_on && !vco_off && !shared_pin_on)
      else $error("clock bits wrong after reset");
endmodule // adc_ctrl_regs_chk

// ==== adc_core_model.sv ====
// decoder core and bitstream source model facing the register bank
`timescale 1ns/1ps
module adc_core_model
   import adc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       anc_load_req,
   input  wire logic       slow,
   input  wire logic [7:0] base,
   output logic            dec_anc_valid,
   output logic [7:0]      dec_anc_byte,
   output logic            dec_crc_fail,
   output logic            dec_data_missing,
   output logic            serial_input_clock,
   output logic            serial_input_data
);
   logic [2:0] n;
   logic       gap;
   logic [7:0] spin;
   wire        go = anc_load_req && n < 3'd5 && !gap;
   initial begin
      {n, gap, spin, dec_anc_valid, dec_crc_fail, dec_data_missing} = '0;
      {serial_input_clock, serial_input_data, dec_anc_byte} = '0;
   end
   // idle byte bus keeps changing so stale data never looks valid
   always @(posedge clk_sys) begin
      spin <= spin + 8'h3B;
      gap <= slow & ~gap;
      dec_anc_valid <= go;
      dec_anc_byte <= go ? base + {5'h0, n} : spin;
      if (!anc_load_req) n <= 3'd0;
      else if (go) n <= n + 3'd1;
   end
   task automatic fault(input logic crc, input logic miss);
      @(posedge clk_sys) #1;
      dec_crc_fail = crc;
      dec_data_missing = miss;
      @(posedge clk_sys) #1;
      dec_crc_fail = 0;
      dec_data_missing = 0;
   endtask
   // data stable around both edges, so either sampling edge sees it
   task automatic send(input logic b);
      serial_input_data = b;
      repeat (8) @(posedge clk_sys);
      #1 serial_input_clock = 1;
      repeat (8) @(posedge clk_sys);
      #1 serial_input_clock = 0;
      repeat (8) @(posedge clk_sys);
      #1 serial_input_data = ~b;
   endtask
endmodule // adc_core_model

// ==== test_adc_ctrl_regs.sv ====
// self-checking bench for the decoder control register bank
`timescale 1ns/1ps
module test_adc_ctrl_regs;
   import adc_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   localparam logic [7:0] IDC = 8'h96; // arbitrary value
   localparam logic [6:0] WA [8] = '{7'h00, 7'h01, 7'h0C, 7'h0D, 7'h0F, 7'h13, 7'h14, 7'h18};
   localparam logic [7:0] WE [8] = '{REV, IDC, 8'h05, 8'h04, 8'h00, 8'h01, 8'h01, 8'h04};
   localparam logic [7:0] SR [10] = '{0, 0, 0, 0, 8'h01, 0, 0, 0, 0, 8'h04};
   logic       clk_sys, rst, bus_sub_load, bus_wr, bus_rd, bus_rvalid, slow, dec_in_decode;
   logic       dec_wants_data, dec_anc_valid, dec_crc_fail, dec_data_missing, sdi_bit, sdi_valid;
   logic       serial_input_clock, serial_input_data, data_req_line, shared_pin_req_mode;
   logic       anc_load_req, soft_reset_pulse, play_active, mute_active, load_fraction;
   logic       crystal_to_out_divider, crystal_to_sys_divider, vco_off, sysclk_on_outclk;
   logic       outclk_pad_on, osc_out_pad_off, shared_pin_on;
   logic [1:0] dec_sync_state;
   logic [7:0] bus_wdata, bus_rdata, pll_multiplier, pll_input_divider, dec_anc_byte, base, cbits;
   int         errors, samples_checked, vcnt, i, n;
   assign cbits = {shared_pin_on, osc_out_pad_off, outclk_pad_on, sysclk_on_outclk, vco_off,
                   crystal_to_sys_divider, crystal_to_out_divider, load_fraction};
   adc_ctrl_regs #(.REVISION(REV), .IDENT_CODE(IDC)) dut (
      .clk_sys, .rst, .bus_sub_load, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_rvalid,
      .load_fraction, .crystal_to_out_divider, .crystal_to_sys_divider, .vco_off,
      .sysclk_on_outclk, .outclk_pad_on, .osc_out_pad_off, .shared_pin_on, .pll_multiplier,
      .pll_input_divider, .serial_input_clock, .serial_input_data, .sdi_bit, .sdi_valid,
      .data_req_line, .shared_pin_req_mode, .dec_in_decode, .dec_wants_data, .dec_crc_fail,
      .dec_data_missing, .dec_sync_state, .dec_anc_valid, .dec_anc_byte, .anc_load_req,
      .soft_reset_pulse, .play_active, .mute_active);
   adc_core_model model (.clk_sys, .anc_load_req, .slow, .base, .dec_anc_valid, .dec_anc_byte,
      .dec_crc_fail, .dec_data_missing, .serial_input_clock, .serial_input_data);
   initial begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (sdi_valid === 1'b1) vcnt++;
   // ------
   // access tasks
   // ------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic op(input logic l, input logic w, input logic r, input logic [7:0] d);
      cyc(1);
      {bus_sub_load, bus_wr, bus_rd, bus_wdata} = {l, w, r, d};
      cyc(1);
      {bus_sub_load, bus_wr, bus_rd, bus_wdata} = {3'b000, ~d};
   endtask
   task automatic sa(input logic [6:0] a);
      op(1, 0, 0, {1'b0, a});
   endtask
   task automatic wr(input logic [7:0] d);
      op(0, 1, 0, d);
   endtask
   // answer stands one cycle, so it is taken right after the read edge
   task automatic rd(input logic [7:0] e);
      op(0, 0, 1, 8'h00);
      chk(bus_rvalid === 1'b1 ? bus_rdata : ~e, e);
   endtask
   function automatic logic [7:0] rst_val(input logic [6:0] a);
      case (a)
         7'h00: return REV;
         7'h01: return IDC;
         7'h05: return 8'h21;
         7'h06: return 8'h0C;
         7'h0C, 7'h13: return 8'h01;
         7'h0D: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction
   // documented addresses only; everything else is reserved
   function automatic logic doc(input logic [6:0] a);
      return a inside {7'h00, 7'h01, [7'h05:7'h07], 7'h0C, 7'h0D, [7'h0F:7'h10], 7'h13, 7'h14, 7'h16,
                       7'h18, 7'h40, [7'h59:7'h5D]};
   endfunction
   task automatic conclude;
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ------
   // main sequence
   // ------
   initial begin
      rst = 1;
      {bus_sub_load, bus_wr, bus_rd, slow, dec_in_decode, dec_wants_data} = '0;
      {bus_wdata, dec_sync_state, base} = {8'h00, 2'b10, 8'h3C};
      {errors, samples_checked, vcnt} = '0;
      cyc(3);
      rst = 0;
      // reserved addresses skipped; a gap means a fresh sub-address
      for (i = 0; i < 26; i++) begin
         if (doc(i[6:0])) begin
            if (!doc(7'(i - 1))) sa(i[6:0]);
            rd(rst_val(i[6:0]));
         end
      end
      chk(cbits, 8'h21);
      sa(7'h05);
      wr(8'hDE);
      wr(8'hA5);
      wr(8'h5A);
      chk(cbits, 8'hDE);
      chk(pll_multiplier, 8'hA5);
      chk(pll_input_divider, 8'h5A);
      for (i = 0; i < 8; i++) begin
         sa(WA[i]);
         if (!(WA[i] inside {7'h00, 7'h01, 7'h0F})) wr(8'hFF);
         sa(WA[i]);
         rd(WE[i]);
      end
      chk({6'h0, mute_active, shared_pin_req_mode}, 8'h03);
      dec_wants_data = 1;
      cyc(2);
      chk({7'h0, data_req_line}, 8'h00);
      sa(7'h0C);
      wr(8'h01);
      cyc(2);
      chk({7'h0, data_req_line}, 8'h01);
      chk({7'h0, play_active}, 8'h00);
      dec_in_decode = 1;
      cyc(1);
      chk({7'h0, play_active}, 8'h01);
      for (i = 0; i < 4; i++) begin
         if (i == 2) begin
            sa(7'h0D);
            wr(8'h00);
         end
         vcnt = 0;
         fork
            model.send(~(i[0] ^ i[1]));
            begin
               cyc(15);
               chk(vcnt[7:0], {7'h0, i[1]});
            end
         join
         chk({7'h0, sdi_bit}, {7'h0, ~(i[0] ^ i[1])});
         chk(vcnt[7:0], 8'h01);
      end
      model.fault(1, 0);
      sa(7'h0F);
      rd(8'h01);
      model.fault(0, 1);
      sa(7'h0F);
      rd(8'h02);
      for (i = 0; i < 2; i++) begin
         slow = i[0];
         base = i[0] ? 8'hC3 : 8'h3C;
         sa(7'h16);
         wr(8'h80);
         cyc(1);
         chk({7'h0, anc_load_req}, 8'h01);
         for (n = 0; n < 40 && anc_load_req !== 1'b0; n++) cyc(1);
         if (n == 40) begin
            errors++;
            $display("[FAIL] %0t refill never finished", $time);
            conclude();
         end
         sa(7'h16);
         rd(8'h00);
         sa(7'h59);
         for (n = 0; n < 5; n++) rd(base + n[7:0]);
      end
      sa(7'h13);
      wr(8'h00);
      sa(7'h10);
      wr(8'h01);
      for (i = 0; i < 10; i++) begin
         if (doc(7'(i + 15))) begin
            if (!doc(7'(i + 14))) sa(7'(i + 15));
            rd(SR[i]);
         end
      end
      sa(7'h05);
      rd(8'hDE);
      sa(7'h59);
      rd(8'h00);
      for (i = 0; i < 4; i++) begin
         dec_sync_state = i[1:0];
         sa(7'h40);
         rd({6'h0, i[1:0]});
      end
      conclude();
   end
endmodule // test_adc_ctrl_regs
bind adc_ctrl_regs adc_ctrl_regs_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus_sub_load(bus_sub_load),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rvalid(bus_rvalid), .load_fraction(load_fraction),
   .outclk_pad_on(outclk_pad_on), .vco_off(vco_off), .shared_pin_on(shared_pin_on), .sdi_valid(sdi_valid),
   .anc_load_req(anc_load_req), .soft_reset_pulse(soft_reset_pulse), .play_active(play_active),
   .mute_active(mute_active), .dec_in_decode(dec_in_decode));
